// ==== src/iprt_input_port.sv ====
// Input port with four change-interrupt systems behind an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
module iprt_input_port
    import iprt_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [NPIN-1:0]   pin_in,
    output logic                   irq,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    logic [NPIN-1:0]   sync1_ff;
    logic [NPIN-1:0]   sync2_ff;
    logic [9:0]        sel_ff;
    logic [NPIN-1:0]   cmp_ff;
    logic [NSYS-1:0]   mask_ff;
    logic [NSYS-1:0]   flag_ff;
    logic [NSYS-1:0]   evt_ff;
    logic [NSYS-1:0]   evt_en_ff;
    logic [NSYS-1:0]   prev_match_ff;
    logic              armed_ff;

    logic              aw_got_ff;
    logic              w_got_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [3:0]        w_data_ff;
    logic              w_lane0_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              rvalid_ff;
    iprt_rd_s          rd_ff;

    // Pin synchroniser; only sync2_ff is looked at downstream
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end
        else
        begin
            sync1_ff <= pin_in; // RULE17
            sync2_ff <= sync1_ff; // RULE17
        end
    end

    // Per-pin match: compare one waits for a fall, zero for a rise
    wire [NPIN-1:0] pin_match = sync2_ff ~^ cmp_ff; // RULE9
    wire [NPIN-1:0] pin_used  = {1'b1, sel_ff}; // RULE6 RULE15
    wire [NPIN-1:0] pin_ok    = pin_match | ~pin_used; // RULE10

    wire [NSYS-1:0] sys_match = {pin_ok[10], &pin_ok[9:8],
                                 &pin_ok[7:4], &pin_ok[3:0]}; // RULE2 RULE15

    // Mismatch to mismatch is not a new event
    wire [NSYS-1:0] sys_event = armed_ff ? (prev_match_ff & ~sys_match)
                                         : '0; // RULE14

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prev_match_ff <= '1;
            armed_ff      <= 1'b0;
        end
        else
        begin
            prev_match_ff <= sys_match;
            armed_ff      <= 1'b1;
        end
    end

    // Write address and data channels, taken in either order
    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready  = !w_got_ff && !bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;

    wire aw_hs    = s_axi_awvalid && s_axi_awready;
    wire w_hs     = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_got_ff && w_got_ff && !bvalid_ff;

    iprt_wr_s wr;
    assign wr.idx   = aw_addr_ff[11:2];
    assign wr.data  = w_data_ff;
    assign wr.lane0 = w_lane0_ff;

    wire wr_sel_hi  = do_write && wr.lane0 && (wr.idx == IDX_SEL_HI);
    wire wr_sel_mid = do_write && wr.lane0 && (wr.idx == IDX_SEL_MID);
    wire wr_sel_lo  = do_write && wr.lane0 && (wr.idx == IDX_SEL_LO);
    wire wr_cmp_hi  = do_write && wr.lane0 && (wr.idx == IDX_CMP_HI);
    wire wr_cmp_mid = do_write && wr.lane0 && (wr.idx == IDX_CMP_MID);
    wire wr_cmp_lo  = do_write && wr.lane0 && (wr.idx == IDX_CMP_LO);
    wire wr_mask    = do_write && wr.lane0 && (wr.idx == IDX_MASK_BANK);
    wire wr_evt     = do_write && wr.lane0 && (wr.idx == IDX_EVT_STATUS);
    wire wr_evt_en  = do_write && wr.lane0 && (wr.idx == IDX_EVT_ENABLE);

    // Flag and pin level indices accept the write but store nothing
    wire wr_mapped = (wr.idx >= IDX_FLAG_SYS3 && wr.idx <= IDX_FLAG_SYS0)
                  || (wr.idx >= IDX_SEL_HI && wr.idx <= IDX_CMP_LO)
                  || (wr.idx >= IDX_MASK_BANK && wr.idx <= IDX_EVT_ENABLE); // RULE3 RULE8

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff  <= 4'h0;
            w_lane0_ff <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_got_ff  <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_hs)
            begin
                w_got_ff   <= 1'b1;
                w_data_ff  <= s_axi_wdata[3:0];
                w_lane0_ff <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_ff && s_axi_bready)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sel_ff    <= RST_SEL; // RULE6
            cmp_ff    <= RST_CMP;
            mask_ff   <= RST_MASK; // RULE13
            evt_en_ff <= RST_EVT;
        end
        else
        begin
            if (wr_sel_hi)
                sel_ff[9:8] <= wr.data[1:0]; // RULE6
            if (wr_sel_mid)
                sel_ff[7:4] <= wr.data; // RULE6
            if (wr_sel_lo)
                sel_ff[3:0] <= wr.data; // RULE6
            if (wr_cmp_hi)
                cmp_ff[10:8] <= wr.data[2:0]; // RULE9
            if (wr_cmp_mid)
                cmp_ff[7:4] <= wr.data; // RULE9
            if (wr_cmp_lo)
                cmp_ff[3:0] <= wr.data; // RULE9
            // Software is expected to change masks with interrupts disabled
            if (wr_mask)
                mask_ff <= wr.data; // RULE11 RULE12
            if (wr_evt_en)
                evt_en_ff <= wr.data;
        end
    end

    // Read channel
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rd_ff.data;
    assign s_axi_rresp   = rd_ff.resp;

    wire       ar_hs  = s_axi_arvalid && s_axi_arready;
    wire [9:0] rd_idx = s_axi_araddr[11:2];

    wire [3:0] flag_rd_hit = {rd_idx == IDX_FLAG_SYS3, rd_idx == IDX_FLAG_SYS2,
                              rd_idx == IDX_FLAG_SYS1, rd_idx == IDX_FLAG_SYS0};
    wire [3:0] flag_clr    = ar_hs ? flag_rd_hit : 4'h0; // RULE4

    logic [3:0] rd_val;
    logic       rd_ok;

    always_comb
    begin
        rd_val = 4'h0;
        rd_ok  = 1'b1;
        unique case (rd_idx)
            IDX_FLAG_SYS3:  rd_val = {3'h0, flag_ff[3]}; // RULE1
            IDX_FLAG_SYS2:  rd_val = {3'h0, flag_ff[2]}; // RULE1
            IDX_FLAG_SYS1:  rd_val = {3'h0, flag_ff[1]}; // RULE1
            IDX_FLAG_SYS0:  rd_val = {3'h0, flag_ff[0]}; // RULE1
            IDX_SEL_HI:     rd_val = {2'h0, sel_ff[9:8]};
            IDX_SEL_MID:    rd_val = sel_ff[7:4];
            IDX_SEL_LO:     rd_val = sel_ff[3:0];
            IDX_LVL_HI:     rd_val = {1'b0, sync2_ff[10:8]}; // RULE7
            IDX_LVL_MID:    rd_val = sync2_ff[7:4]; // RULE7
            IDX_LVL_LO:     rd_val = sync2_ff[3:0]; // RULE7
            IDX_CMP_HI:     rd_val = {1'b0, cmp_ff[10:8]};
            IDX_CMP_MID:    rd_val = cmp_ff[7:4];
            IDX_CMP_LO:     rd_val = cmp_ff[3:0];
            IDX_MASK_BANK:  rd_val = mask_ff; // RULE11
            IDX_EVT_STATUS: rd_val = evt_ff;
            IDX_EVT_ENABLE: rd_val = evt_en_ff;
            default:        rd_ok  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rd_ff     <= '0;
        end
        else if (ar_hs)
        begin
            rvalid_ff    <= 1'b1;
            rd_ff.data   <= {28'h0, rd_val};
            rd_ff.resp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end

    // Flags: an event in the clearing cycle wins, so it is never lost
    wire [3:0] evt_w1c = wr_evt ? wr.data : 4'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flag_ff <= RST_FLAG; // RULE5
            evt_ff  <= RST_EVT;
        end
        else
        begin
            flag_ff <= (flag_ff & ~flag_clr) | sys_event; // RULE1 RULE4
            evt_ff  <= (evt_ff & ~evt_w1c) | sys_event;
        end
    end

    // Flag request holds until the flag is read away; event request holds until its status bit is written one
    wire irq_sys = |(flag_ff & mask_ff); // RULE16
    wire irq_evt = |(evt_ff & evt_en_ff);
    assign irq = irq_sys || irq_evt;

    // Checks
    chk_flag_reset: assert property (@(posedge aclk) // RULE5 RULE13
        $rose(aresetn) |-> flag_ff == 4'h0 && mask_ff == 4'h0)
        else $error("flags or masks not clear after reset");
    chk_sel_reset: assert property (@(posedge aclk)
        $rose(aresetn) |-> sel_ff == RST_SEL && cmp_ff == RST_CMP
        && evt_ff == RST_EVT && evt_en_ff == RST_EVT)
        else $error("configuration not clear after reset");
    chk_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
        sys_event[0] |=> flag_ff[0])
        else $error("event did not set flag");
    chk_flag_set_lone: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1 RULE15
        sys_event[3] |=> flag_ff[3])
        else $error("bit 10 event did not set flag");
    chk_read_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
        ar_hs && flag_rd_hit[1] && !sys_event[1] |=> !flag_ff[1])
        else $error("flag not cleared by read");
    chk_read_clear_lo: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
        ar_hs && flag_rd_hit[0] && !sys_event[0] |=> !flag_ff[0])
        else $error("low flag not cleared by read");
    chk_flag_nowrite: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
        !sys_event[2] && !flag_clr[2] |=> flag_ff[2] == $past(flag_ff[2]))
        else $error("flag changed without event or read");
    chk_flags_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
        sys_event == 4'h0 && flag_clr == 4'h0 |=> flag_ff == $past(flag_ff))
        else $error("flags changed without event or read");
    chk_flag_wr_ok: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
        do_write && wr.idx == IDX_FLAG_SYS0 |=> s_axi_bresp == RESP_OKAY)
        else $error("flag write not accepted");
    chk_unsel_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
        sel_ff[3:0] == 4'h0 |-> !sys_event[0])
        else $error("unselected pins raised an event");
    chk_unsel_mid: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
        sel_ff[7:4] == 4'h0 |-> !sys_event[1])
        else $error("unselected middle pins raised an event");
    chk_unsel_hi: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
        sel_ff[9:8] == 2'h0 |-> !sys_event[2])
        else $error("unselected high pins raised an event");
    chk_fall_edge: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9 RULE10
        armed_ff && sel_ff[0] && $stable(sel_ff) && $stable(cmp_ff) && cmp_ff[0]
        && ((sync2_ff[3:1] ^ cmp_ff[3:1]) & sel_ff[3:1]) == 3'h0 && $stable(sync2_ff[3:1])
        && $past(sync2_ff[0]) && !sync2_ff[0] |-> sys_event[0])
        else $error("selected falling edge missed");
    chk_rise_edge: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9 RULE10
        armed_ff && sel_ff[0] && $stable(sel_ff) && $stable(cmp_ff) && !cmp_ff[0]
        && ((sync2_ff[3:1] ^ cmp_ff[3:1]) & sel_ff[3:1]) == 3'h0 && $stable(sync2_ff[3:1])
        && !$past(sync2_ff[0]) && sync2_ff[0] |-> sys_event[0])
        else $error("selected rising edge missed");
    chk_mis_to_mis: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
        !prev_match_ff[1] |-> !sys_event[1])
        else $error("event without a prior match");
    chk_lone_pin: assert property (@(posedge aclk) disable iff (!aresetn) // RULE15
        armed_ff && $past(sync2_ff[10] == cmp_ff[10]) && sync2_ff[10] != cmp_ff[10]
        && $stable(cmp_ff[10]) |-> sys_event[3])
        else $error("bit 10 change did not raise an event");
    chk_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
        ##2 sync2_ff == $past(pin_in, 2))
        else $error("pin not delayed by two stages");
    chk_level_read: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        ar_hs && rd_idx == IDX_LVL_LO |=> s_axi_rdata[3:0] == $past(sync2_ff[3:0]))
        else $error("pin level read wrong");
    chk_level_hi: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        ar_hs && rd_idx == IDX_LVL_HI |=> s_axi_rdata[3:0] == {1'b0, $past(sync2_ff[10:8])})
        else $error("high pin level read wrong");
    chk_level_ro: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
        do_write && wr.idx == IDX_LVL_LO
        |=> $stable(sel_ff) && $stable(cmp_ff) && $stable(mask_ff))
        else $error("pin level write changed a register");
    chk_mask_read: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
        ar_hs && rd_idx == IDX_MASK_BANK |=> s_axi_rdata[3:0] == $past(mask_ff))
        else $error("mask read back wrong");
    chk_irq_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RULE16
        flag_ff[0] && mask_ff[0] && !flag_clr[0] && !wr_mask |=> irq)
        else $error("request dropped while flag and mask set");
    chk_irq_off: assert property (@(posedge aclk) disable iff (!aresetn) // RULE16
        (flag_ff & mask_ff) == 4'h0 && (evt_ff & evt_en_ff) == 4'h0 |-> !irq)
        else $error("request without an unmasked flag");
    chk_evt_set: assert property (@(posedge aclk) disable iff (!aresetn)
        sys_event[0] |=> evt_ff[0])
        else $error("event did not set status");
    chk_evt_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_evt && wr.data[0] && !sys_event[0] |=> !evt_ff[0])
        else $error("status not cleared by write one");
    chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid)
        else $error("write response missing");
    chk_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_rdata_upper: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0)
        else $error("read data upper bits not zero");

    cov_event_lo:   cover property (@(posedge aclk) disable iff (!aresetn) sys_event[0]);
    cov_event_lone: cover property (@(posedge aclk) disable iff (!aresetn) sys_event[3]);
    cov_read_flag:  cover property (@(posedge aclk) disable iff (!aresetn)
        ar_hs && flag_rd_hit[0] && flag_ff[0]);
    cov_irq:        cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
    cov_evt_irq:    cover property (@(posedge aclk) disable iff (!aresetn) irq_evt && !irq_sys);

endmodule

// ==== src/iprt_pkg.sv ====
// Package with register map, reset values and carrier types for the input port unit
// How it works
// [RULE1] Factor flag reads one after system interrupt
// [RULE2] Flags serve bits 0-3, 4-7, 8-9, 10
// [RULE3] Writes to factor flags are ignored
// [RULE4] Reading a factor flag clears it
// [RULE5] Reset clears all factor flags
// [RULE6] Source select one includes pin in condition
// [RULE7] Pin level register reads pin state
// [RULE8] Pin level register is read-only
// [RULE9] Compare bit one falling, zero rising
// [RULE10] Compare used only for selected pins
// [RULE11] One readable mask bit per system
// [RULE12] Software writes masks only when interrupts disabled
// [RULE13] Reset clears all mask bits
// [RULE14] Interrupt only on match to mismatch
// [RULE15] Bit 10 is its own system
// [RULE16] Request while flag and mask set
// [RULE17] Pins synchronised before detection
package iprt_pkg;

    localparam int ADDR_W = 12;
    localparam int NPIN   = 11;
    localparam int NSYS   = 4;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_FLAG_SYS3  = 10'h0C0;
    localparam logic [9:0] IDX_FLAG_SYS2  = 10'h0C1;
    localparam logic [9:0] IDX_FLAG_SYS1  = 10'h0C2;
    localparam logic [9:0] IDX_FLAG_SYS0  = 10'h0C3;
    localparam logic [9:0] IDX_SEL_HI     = 10'h0C6;
    localparam logic [9:0] IDX_SEL_MID    = 10'h0C7;
    localparam logic [9:0] IDX_SEL_LO     = 10'h0C8;
    localparam logic [9:0] IDX_LVL_HI     = 10'h0C9;
    localparam logic [9:0] IDX_LVL_MID    = 10'h0CA;
    localparam logic [9:0] IDX_LVL_LO     = 10'h0CB;
    localparam logic [9:0] IDX_CMP_HI     = 10'h0CC;
    localparam logic [9:0] IDX_CMP_MID    = 10'h0CD;
    localparam logic [9:0] IDX_CMP_LO     = 10'h0CE;
    localparam logic [9:0] IDX_MASK_BANK  = 10'h0D0;
    localparam logic [9:0] IDX_EVT_STATUS = 10'h0D1;
    localparam logic [9:0] IDX_EVT_ENABLE = 10'h0D2;

    localparam logic [3:0]  RST_FLAG = 4'h0;
    localparam logic [9:0]  RST_SEL  = 10'h000;
    localparam logic [10:0] RST_CMP  = 11'h000;
    localparam logic [3:0]  RST_MASK = 4'h0;
    localparam logic [3:0]  RST_EVT  = 4'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  resp;
    } iprt_rd_s;

    typedef struct packed {
        logic [9:0]  idx;
        logic [3:0]  data;
        logic        lane0;
    } iprt_wr_s;

endpackage

// ==== testbench/iprt_switch_model.sv ====
// Switch bank model driving the port pins from a requested level
`timescale 1ns/100ps
module iprt_switch_model
    import iprt_pkg::*;
(
    input  wire logic            aclk,
    input  wire logic [NPIN-1:0] level_req,
    output logic      [NPIN-1:0] pin_out
);
    initial pin_out = '0;
    // Contacts settle one cycle after the request, unrelated to bus timing
    always @(posedge aclk)
    begin
        pin_out <= level_req;
    end
endmodule

// ==== testbench/iprt_input_port_tb.sv ====
// Self-checking bench for the input port interrupt unit
`timescale 1ns/100ps
module iprt_input_port_tb
    import iprt_pkg::*;
;
    logic              aclk;
    logic              aresetn;
    logic [NPIN-1:0]   pin_req;
    logic [NPIN-1:0]   pin_in;
    logic              irq;
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic              awready;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready;
    int                miscompares = 0;
    int                n_checks    = 0;
    int                cycles      = 0;

    iprt_switch_model i_iprt_switch_model (.aclk(aclk), .level_req(pin_req), .pin_out(pin_in));

    iprt_input_port i_iprt_input_port (
        .aclk(aclk), .aresetn(aresetn), .pin_in(pin_in), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic finish_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles the scenarios need
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic axi_wr(input logic [9:0] idx, input logic [3:0] d, output logic [1:0] r);
        awaddr  <= {idx, 2'b00};
        wdata   <= {28'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [3:0] d);
        logic [1:0] r;
        axi_wr(idx, d, r);
    endtask

    task automatic rd_chk(input string what, input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(idx, d, r);
        check(what, d, exp);
    endtask

    // Pin edge needs sync plus detect cycles before the flag shows
    task automatic drive(input logic [NPIN-1:0] v);
        pin_req <= v;
        repeat (6) @(posedge aclk);
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 4; i++)
            rd_chk("flag rst", IDX_FLAG_SYS3 + 10'(i), 32'h0);
        rd_chk("mask rst", IDX_MASK_BANK, 32'h0);
        rd_chk("evt rst", IDX_EVT_STATUS, 32'h0);
        check("irq rst", {31'h0, irq}, 32'h0);
        axi_rd(10'h0C4, d, r);
        check("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
        wr(IDX_MASK_BANK, 4'hF);
        rd_chk("mask rb", IDX_MASK_BANK, 32'hF);
        wr(IDX_MASK_BANK, 4'h0);
    endtask

    task automatic t_levels();
        drive(11'h5A5);
        rd_chk("lvl lo", IDX_LVL_LO, 32'h5);
        rd_chk("lvl mid", IDX_LVL_MID, 32'hA);
        rd_chk("lvl hi", IDX_LVL_HI, 32'h5);
        wr(IDX_LVL_LO, 4'hA);
        rd_chk("lvl ro", IDX_LVL_LO, 32'h5);
        rd_chk("lone rise", IDX_FLAG_SYS3, 32'h1);
        drive(11'h000);
        rd_chk("lone back", IDX_FLAG_SYS3, 32'h0);
    endtask

    task automatic t_systems();
        logic [9:0] sel_idx[3] = '{IDX_SEL_LO, IDX_SEL_MID, IDX_SEL_HI};
        int         pin_no[4]  = '{0, 4, 8, 10};
        logic [9:0] flg[4]     = '{IDX_FLAG_SYS0, IDX_FLAG_SYS1, IDX_FLAG_SYS2, IDX_FLAG_SYS3};
        for (int s = 0; s < 4; s++)
        begin
            if (s < 3)
                wr(sel_idx[s], 4'h1);
            // Masks change only while no request is pending, as software must
            wr(IDX_MASK_BANK, 4'(1 << s));
            check("irq idle", {31'h0, irq}, 32'h0);
            drive(11'(1 << pin_no[s]));
            check("irq set", {31'h0, irq}, 32'h1);
            wr(flg[s], 4'h0);
            for (int j = 0; j < 4; j++)
                rd_chk("flag map", flg[j], {31'h0, j == s});
            check("irq clr", {31'h0, irq}, 32'h0);
            drive(11'h000);
            rd_chk("flag quiet", flg[s], 32'h0);
        end
        wr(IDX_MASK_BANK, 4'h0);
    endtask

    task automatic t_compare();
        wr(IDX_SEL_LO, 4'h1);
        drive(11'h002);
        rd_chk("unselected", IDX_FLAG_SYS0, 32'h0);
        drive(11'h000);
        wr(IDX_SEL_LO, 4'h3);
        drive(11'h001);
        rd_chk("rise", IDX_FLAG_SYS0, 32'h1);
        drive(11'h003);
        rd_chk("miss to miss", IDX_FLAG_SYS0, 32'h0);
        wr(IDX_CMP_LO, 4'h3);
        rd_chk("cmp rb", IDX_CMP_LO, 32'h3);
        rd_chk("cmp match", IDX_FLAG_SYS0, 32'h0);
        drive(11'h002);
        rd_chk("fall", IDX_FLAG_SYS0, 32'h1);
        rd_chk("read clr", IDX_FLAG_SYS0, 32'h0);
    endtask

    // Status bits collected every event so far; enable routes them to irq
    task automatic t_events();
        rd_chk("evt sticky", IDX_EVT_STATUS, 32'hF);
        wr(IDX_EVT_STATUS, 4'hF);
        rd_chk("evt w1c", IDX_EVT_STATUS, 32'h0);
        wstrb <= 4'h0;
        wr(IDX_EVT_ENABLE, 4'h1);
        wstrb <= 4'hF;
        rd_chk("evt strb", IDX_EVT_ENABLE, 32'h0);
        wr(IDX_EVT_ENABLE, 4'h1);
        rd_chk("evt en rb", IDX_EVT_ENABLE, 32'h1);
        check("irq evt idle", {31'h0, irq}, 32'h0);
        drive(11'h003);
        drive(11'h002);
        check("irq evt", {31'h0, irq}, 32'h1);
        rd_chk("evt flag", IDX_FLAG_SYS0, 32'h1);
        check("irq evt hold", {31'h0, irq}, 32'h1);
        wr(IDX_EVT_STATUS, 4'h1);
        check("irq evt clr", {31'h0, irq}, 32'h0);
        rd_chk("evt clr", IDX_EVT_STATUS, 32'h0);
        wr(IDX_EVT_ENABLE, 4'h0);
    endtask

    initial
    begin
        aresetn <= 1'b0;
        pin_req <= '0;
        awaddr  <= '0;
        awvalid <= 1'b0;
        wdata   <= '0;
        wstrb   <= 4'hF;
        wvalid  <= 1'b0;
        bready  <= 1'b0;
        araddr  <= '0;
        arvalid <= 1'b0;
        rready  <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_levels();
        t_systems();
        t_compare();
        t_events();
        finish_test();
    end
endmodule
